//--- hw/uhfp_pkg.sv
package uhfp_pkg;
  // Register byte offsets
  localparam logic [8:0] UHFP_CMD_OFS = 9'h020;
  localparam logic [8:0] UHFP_FRIDX_OFS = 9'h02C;
  localparam logic [8:0] UHFP_CFG_OFS = 9'h060;
  localparam logic [8:0] UHFP_PORT_OFS = 9'h064;
  localparam logic [8:0] UHFP_PHY_OFS = 9'h068;
  // Command register fields
  localparam int UHFP_CMD_RUN = 0;
  localparam int UHFP_CMD_HCRST = 1;
  localparam int UHFP_CMD_LSIZE = 2;
  localparam int UHFP_LSIZE_W = 2;
  // Frame index
  localparam int UHFP_FRIDX_W = 14;
  localparam logic [13:0] UHFP_FRIDX_RST = 14'h0000;
  localparam int UHFP_FLIST_LSB = 3;
  // Port field positions
  localparam int UHFP_P_CCS = 0;
  localparam int UHFP_P_CSC = 1;
  localparam int UHFP_P_ENA = 2;
  localparam int UHFP_P_RESUME = 6;
  localparam int UHFP_P_SUSPEND = 7;
  localparam int UHFP_P_BUSRST = 8;
  localparam int UHFP_P_LINE = 10;
  localparam int UHFP_P_POWER = 12;
  localparam int UHFP_P_OWNER = 13;
  localparam int UHFP_P_IND = 14;
  localparam int UHFP_P_TEST = 16;
  localparam logic UHFP_OWNER_RST = 1'b1;
  // Timing
  localparam int UHFP_CLK_HZ = 40_000_000;
  localparam int UHFP_UFRAME_US = 125;
  localparam int UHFP_UFRAME_CYC = UHFP_CLK_HZ / 1_000_000 * UHFP_UFRAME_US;
  localparam int UHFP_BUSRST_US = 50;
  localparam int UHFP_BUSRST_CYC = UHFP_CLK_HZ / 1_000_000 * UHFP_BUSRST_US;
  localparam int UHFP_CNT_W = 13;
endpackage

//--- hw/uhfp_regs.sv
`timescale 1ns/10ps
// Operation
// (RL1) Frame index increments once per 125 us microframe.
// (RL2) Frame list entry chosen from index bits 3 upward, width by list size.
// (RL3) Software writes frame index only as full 32-bit word.
// (RL4) Software never writes frame index while running.
// (RL5) Frame index writes change subsequent SOF frame number.
// (RL6) Frame index is 14 bits, resets zero; upper bits reserved.
// (RL7) Software sets configured flag last; it drives port routing.
// (RL8) Port register resets only at power-up or controller reset command.
// (RL9) After reset port shows nothing attached and disabled.
// (RL10) Port state changes ignored until port power is set.
// (RL11) Software waits up to 20 ms for power stability.
// (RL12) Nonzero port test control selects that test mode.
// (RL13) Indicator writes ignored when indicator capability is zero.
// (RL14) Owner clears on configured rise, forced one while configured zero.
// (RL15) Port power behaviour follows power-control capability.
// (RL16) Line state shows D+ in bit 11, D- in bit 10.
// (RL17) Bit 8 reads one while port is held in bus reset.
// (RL18) Bit 7 is one while the port is suspended.
// (RL19) Bit 6 is one while resume signalling is present.
// (RL20) Bit 2 reads one when port enabled.
// (RL21) Bit 0 shows attachment; bit 1 flags its change.
// (RL22) Without port power, connect, change, reset, suspend, indicator read zero.
// (RL23) Run/stop set runs the schedule, clear halts it.
// (RL24) Controller reset bit resets controller and port register.
// (RL25) Connect change clears on written one, zero leaves it.
module uhfp_regs
  import uhfp_pkg::*;
#(
  parameter logic PWR_CTL_CAP = 1'b1,
  parameter logic PIND_CAP = 1'b1
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic line_dp,
  input wire logic line_dm,
  input wire logic dev_attached,
  input wire logic resume_detect,
  output logic schedule_run,
  output logic [13:0] sof_frame_number,
  output logic [9:0] frame_list_entry,
  output logic [3:0] port_test_mode,
  output logic [1:0] port_indicator,
  output logic port_power_out,
  output logic port_owner_out,
  output logic port_reset_drive,
  output logic port_suspend_out,
  output logic resume_drive
);
  // Pin synchronisers
  logic [3:0] pins_s;
  uhfp_sync2 #(.W(4)) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .async_in({line_dp, line_dm, dev_attached, resume_detect}),
    .sync_out(pins_s)
  );
  wire dp_s = pins_s[3];
  wire dm_s = pins_s[2];
  wire att_s = pins_s[1];
  wire res_in_s = pins_s[0];

  // Registers
  logic run_stop;
  logic hc_reset_pend;
  logic [UHFP_LSIZE_W-1:0] frame_list_size;
  logic [UHFP_FRIDX_W-1:0] frame_index;
  logic configured_flag;
  logic [3:0] port_test_control;
  logic [1:0] port_indicator_control;
  logic port_owner;
  logic port_power;
  logic port_in_reset;
  logic port_suspended;
  logic force_resume;
  logic port_enabled;
  logic connect_change;
  logic connect_present;
  logic [UHFP_CNT_W-1:0] uframe_cnt;
  logic [UHFP_CNT_W-1:0] brst_cnt;
  logic ack;

  // Bus decode; one wait cycle per access
  wire req = avs_read | avs_write;
  wire wr_go = avs_write & ack;
  wire full_word = &avs_byteenable;
  wire wr_cmd = wr_go & (avs_address == UHFP_CMD_OFS);
  wire wr_frx = wr_go & (avs_address == UHFP_FRIDX_OFS) & full_word; // RL3
  wire wr_cfg = wr_go & (avs_address == UHFP_CFG_OFS) & avs_byteenable[0];
  wire wr_port = wr_go & (avs_address == UHFP_PORT_OFS);
  // Controller reset wipes the port well too
  wire ctl_rst = srst | hc_reset_pend; // RL8 RL24
  // Port state writes gated by power when power control exists
  wire pwr_ok = port_power | ~PWR_CTL_CAP; // RL10 RL15
  wire wr_pstate = wr_port & pwr_ok;
  wire [31:0] wd = avs_writedata;
  wire uframe_end = (uframe_cnt == UHFP_CNT_W'(UHFP_UFRAME_CYC - 1));

  assign avs_waitrequest = req & ~ack;

  // Frame list mask by chosen size: 1024, 512, 256 entries
  function automatic logic [9:0] uhfp_fl_mask(input logic [1:0] size_sel);
    case (size_sel)
      2'h1: uhfp_fl_mask = 10'h1FF;
      2'h2: uhfp_fl_mask = 10'h0FF;
      default: uhfp_fl_mask = 10'h3FF;
    endcase
  endfunction

  assign schedule_run = run_stop; // RL23
  assign sof_frame_number = frame_index; // RL5 RL6
  assign frame_list_entry = frame_index[UHFP_FLIST_LSB +: 10] & uhfp_fl_mask(frame_list_size); // RL2
  assign port_test_mode = port_test_control; // RL12
  assign port_indicator = port_power ? port_indicator_control : 2'h0;
  assign port_power_out = port_power;
  assign port_owner_out = port_owner;
  assign port_reset_drive = port_in_reset;
  assign port_suspend_out = port_suspended;
  assign resume_drive = force_resume;

  // Port register read image; power-off masks status
  logic [31:0] port_img;
  always_comb begin
    port_img = 32'h0000_0000;
    port_img[UHFP_P_TEST +: 4] = port_test_control;
    port_img[UHFP_P_IND +: 2] = port_power ? port_indicator_control : 2'h0; // RL22
    port_img[UHFP_P_OWNER] = port_owner;
    port_img[UHFP_P_POWER] = port_power;
    port_img[UHFP_P_LINE + 1] = dp_s; // RL16
    port_img[UHFP_P_LINE] = dm_s; // RL16
    port_img[UHFP_P_BUSRST] = port_power & port_in_reset; // RL17 RL22
    port_img[UHFP_P_SUSPEND] = port_power & port_suspended; // RL18 RL22
    port_img[UHFP_P_RESUME] = force_resume | (port_suspended & res_in_s); // RL19
    port_img[UHFP_P_ENA] = port_enabled; // RL20
    port_img[UHFP_P_CSC] = port_power & connect_change; // RL21 RL22
    port_img[UHFP_P_CCS] = port_power & connect_present; // RL21 RL22
  end

  // Read mux; unmapped reads zero
  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address)
      UHFP_CMD_OFS: rd_mux = {28'h0000000, frame_list_size, 1'b0, run_stop};
      UHFP_FRIDX_OFS: rd_mux = {18'h00000, frame_index}; // RL6
      UHFP_CFG_OFS: rd_mux = {31'h00000000, configured_flag};
      UHFP_PORT_OFS: rd_mux = port_img;
      UHFP_PHY_OFS: rd_mux = {30'h00000000, PIND_CAP, PWR_CTL_CAP};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus handshake and read data register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack <= req & ~ack;
      if (avs_read & ~ack) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Command register; reset bit self-clears after one cycle
  always_ff @(posedge core_clk) begin
    if (ctl_rst) begin
      run_stop <= 1'b0;
      frame_list_size <= '0;
      hc_reset_pend <= 1'b0;
    end else if (wr_cmd) begin
      run_stop <= wd[UHFP_CMD_RUN]; // RL23
      frame_list_size <= wd[UHFP_CMD_LSIZE +: UHFP_LSIZE_W];
      hc_reset_pend <= wd[UHFP_CMD_HCRST]; // RL24
    end
  end

  // Microframe timer and frame index; write overrides the tick
  always_ff @(posedge core_clk) begin
    if (ctl_rst) begin
      uframe_cnt <= '0;
      frame_index <= UHFP_FRIDX_RST; // RL6
    end else begin
      if (!run_stop || uframe_end) begin
        uframe_cnt <= '0;
      end else begin
        uframe_cnt <= uframe_cnt + 1'b1;
      end
      if (wr_frx) begin
        frame_index <= wd[UHFP_FRIDX_W-1:0]; // RL5
      end else if (run_stop && uframe_end) begin
        frame_index <= frame_index + 1'b1; // RL1
      end
    end
  end

  // Configured flag
  always_ff @(posedge core_clk) begin
    if (ctl_rst) begin
      configured_flag <= 1'b0;
    end else if (wr_cfg) begin
      configured_flag <= wd[0]; // RL7
    end
  end

  // Port owner follows configured flag edges
  wire cfg_rise = wr_cfg & wd[0] & ~configured_flag;
  always_ff @(posedge core_clk) begin
    if (ctl_rst) begin
      port_owner <= UHFP_OWNER_RST; // RL14
    end else if (cfg_rise) begin
      port_owner <= 1'b0; // RL14
    end else if (!configured_flag) begin
      port_owner <= 1'b1; // RL14
    end else if (wr_port) begin
      port_owner <= wd[UHFP_P_OWNER];
    end
  end

  // Power and indicator; power fixed on without control capability
  always_ff @(posedge core_clk) begin
    if (ctl_rst) begin
      port_power <= ~PWR_CTL_CAP; // RL15
      port_indicator_control <= 2'h0;
      port_test_control <= 4'h0;
    end else begin
      if (wr_port && PWR_CTL_CAP) begin
        port_power <= wd[UHFP_P_POWER]; // RL15
      end
      if (wr_pstate && PIND_CAP) begin
        port_indicator_control <= wd[UHFP_P_IND +: 2]; // RL13
      end
      if (wr_pstate) begin
        port_test_control <= wd[UHFP_P_TEST +: 4]; // RL12
      end
    end
  end

  // Bus reset timer; enables port when it ends if still attached
  wire brst_done = port_in_reset & (brst_cnt == UHFP_CNT_W'(UHFP_BUSRST_CYC - 1));
  always_ff @(posedge core_clk) begin
    if (ctl_rst) begin
      port_in_reset <= 1'b0;
      brst_cnt <= '0;
      port_enabled <= 1'b0; // RL9
    end else begin
      if (wr_pstate && wd[UHFP_P_BUSRST] && !port_in_reset) begin
        port_in_reset <= 1'b1;
        brst_cnt <= '0;
        port_enabled <= 1'b0;
      end else if (brst_done) begin
        port_in_reset <= 1'b0; // RL17
        port_enabled <= connect_present; // RL20
      end else begin
        if (port_in_reset) begin
          brst_cnt <= brst_cnt + 1'b1;
        end
        // Power loss abandons a bus reset; an unpowered port drives no bus reset
        if (!port_power) begin
          port_in_reset <= 1'b0; // RL22
        end
        // Software may only disable; detach also disables
        if ((wr_pstate && !wd[UHFP_P_ENA]) || !connect_present || !port_power) begin
          port_enabled <= 1'b0;
        end
      end
    end
  end

  // Suspend and resume
  always_ff @(posedge core_clk) begin
    if (ctl_rst) begin
      port_suspended <= 1'b0;
      force_resume <= 1'b0;
    end else if (wr_pstate) begin
      port_suspended <= wd[UHFP_P_SUSPEND] & port_enabled; // RL18
      force_resume <= wd[UHFP_P_RESUME]; // RL19
    end else if (!port_enabled || !port_power) begin
      port_suspended <= 1'b0;
      force_resume <= 1'b0;
    end
  end

  // Connect status and sticky change; a new change beats the clear
  wire conn_diff = att_s ^ connect_present;
  always_ff @(posedge core_clk) begin
    if (ctl_rst) begin
      connect_present <= 1'b0; // RL9
      connect_change <= 1'b0;
    end else begin
      connect_present <= port_power & att_s; // RL21
      if (port_power && conn_diff) begin
        connect_change <= 1'b1; // RL21
      end else if (wr_pstate && wd[UHFP_P_CSC]) begin
        connect_change <= 1'b0; // RL25
      end
    end
  end
endmodule

//--- hw/uhfp_sync2.sv
`timescale 1ns/10ps
// Two-flop synchroniser for pin levels
module uhfp_sync2 #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

//--- tb/uhfp_regs_checker.sv
`timescale 1ns/10ps
// Relations between bus cycles and port outputs
module uhfp_regs_checker
  import uhfp_pkg::*;
#(
  parameter logic PWR_CTL_CAP = 1'b1
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic line_dp,
  input wire logic line_dm,
  input wire logic dev_attached,
  input wire logic resume_detect,
  input wire logic schedule_run,
  input wire logic [13:0] sof_frame_number,
  input wire logic [9:0] frame_list_entry,
  input wire logic [3:0] port_test_mode,
  input wire logic [1:0] port_indicator,
  input wire logic port_power_out,
  input wire logic port_owner_out,
  input wire logic port_reset_drive,
  input wire logic port_suspend_out,
  input wire logic resume_drive
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Accesses land only on the edge where waitrequest is low
  wire logic wr_done = avs_write && !avs_waitrequest;
  wire logic rd_done = avs_read && !avs_waitrequest;
  sequence cfg_wr(v);
    wr_done && avs_address == UHFP_CFG_OFS && avs_writedata[0] == v;
  endsequence
  rst_vals_a: assert property ($fell(srst) |-> sof_frame_number == 14'h0000
    && port_owner_out && port_power_out == !PWR_CTL_CAP && !schedule_run && !port_reset_drive)
    else $error("reset values wrong");
  frame_step_a: assert property (!$past(srst) && !$past(avs_write) &&
    !$past(avs_write, 2) && $changed(sof_frame_number) |->
    sof_frame_number == $past(sof_frame_number) + 14'h0001) else $error("index jump");
  idle_hold_a: assert property (!schedule_run && !avs_write && !$past(avs_write)
    |=> $stable(sof_frame_number)) else $error("index moved while stopped");
  list_entry_a: assert property (frame_list_entry[7:0] == sof_frame_number[10:3])
    else $error("list entry not from index");
  // Two idle cycles let a power-off write settle the gated fields
  unpowered_a: assert property (!port_power_out [*2] |-> port_indicator == 2'h0
    && !port_reset_drive && !port_suspend_out) else $error("unpowered field set");
  owner_force_a: assert property (cfg_wr(1'b0) |-> ##[1:2] port_owner_out)
    else $error("owner not forced");
  owner_clear_a: assert property (cfg_wr(1'b0) ##2 cfg_wr(1'b1) |->
    ##[1:2] !port_owner_out) else $error("owner not cleared");
  port_read_a: assert property (rd_done && avs_address == UHFP_PORT_OFS |->
    avs_readdata[31:12] == {12'h000, $past(port_test_mode), $past(port_indicator),
    $past(port_owner_out), $past(port_power_out)} && avs_readdata[8:7] ==
    {$past(port_reset_drive), $past(port_suspend_out)}) else $error("port readback");
  index_read_a: assert property (rd_done && avs_address == UHFP_FRIDX_OFS |->
    avs_readdata == {18'h0, $past(sof_frame_number)}) else $error("index readback");
endmodule
bind uhfp_regs uhfp_regs_checker #(.PWR_CTL_CAP(PWR_CTL_CAP)) chk_i (.*);

//--- tb/uhfp_usb_port.sv
`timescale 1ns/10ps
// Downstream peripheral on the port pins
module uhfp_usb_port (
  input wire logic plug,
  input wire logic port_power_out,
  input wire logic port_reset_drive,
  input wire logic resume_drive,
  output logic line_dp,
  output logic line_dm,
  output logic dev_attached,
  output logic resume_detect
);
  // Unpowered port shows nothing; pull-downs give SE0 when empty or in reset
  assign dev_attached = plug && port_power_out;
  assign line_dp = dev_attached && !port_reset_drive && !resume_drive;
  assign line_dm = dev_attached && resume_drive && !port_reset_drive;
  assign resume_detect = 1'b0; // Peripheral never wakes the host here
endmodule

//--- tb/usb_host_frame_port_regs_tb.sv
`timescale 1ns/10ps
module usb_host_frame_port_regs_tb
  import uhfp_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [8:0] avs_address = 9'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic plug = 1'b0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, line_dp, line_dm, dev_attached, resume_detect, schedule_run;
  logic [13:0] sof_frame_number;
  logic [9:0] frame_list_entry;
  logic [3:0] port_test_mode;
  logic [1:0] port_indicator;
  logic port_power_out, port_owner_out, port_reset_drive, port_suspend_out, resume_drive;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  uhfp_regs uut (.*);
  uhfp_usb_port peer (.*);
  // 40 MHz core clock
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic complete_run();
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low; caller releases in the same step
  task automatic bus(input logic r, input logic [8:0] a, input logic [31:0] d,
    input logic [3:0] be);
    avs_read <= r;
    avs_write <= !r;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
  endtask
  task automatic idle();
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b0, a, d, 4'hF);
    idle();
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    bus(1'b1, a, 32'h0, 4'hF);
    idle();
    chk(q, exp);
  endtask
  task automatic t_reset();
    rd(UHFP_PORT_OFS, 32'h0000_2000);
    rd(UHFP_FRIDX_OFS, 32'h0);
    rd(9'h100, 32'h0);
  endtask
  // Port writes dropped until power is on, then attach shows up
  task automatic t_power();
    plug <= 1'b1;
    wr(UHFP_PORT_OFS, 32'h0005_C080);
    rd(UHFP_PORT_OFS, 32'h0000_2000);
    wr(UHFP_PORT_OFS, 32'h0000_1000);
    repeat (4) @(posedge core_clk);
    wr(UHFP_PORT_OFS, 32'h0005_D000);
    rd(UHFP_PORT_OFS, 32'h0005_F803);
    chk({26'h0, port_test_mode, port_indicator}, 32'h17);
    wr(UHFP_PORT_OFS, 32'h0000_1006);
    rd(UHFP_PORT_OFS, 32'h0000_3801);
  endtask
  // Back-to-back flag writes give a clean rising edge
  task automatic t_owner();
    bus(1'b0, UHFP_CFG_OFS, 32'h0, 4'hF);
    wr(UHFP_CFG_OFS, 32'h1);
    rd(UHFP_PORT_OFS, 32'h0000_1801);
    wr(UHFP_CFG_OFS, 32'h0);
    rd(UHFP_PORT_OFS, 32'h0000_3801);
  endtask
  // Bus reset, then suspend, then driven resume; pins settle through the synchroniser
  task automatic t_busreset();
    wr(UHFP_PORT_OFS, 32'h0000_1100);
    repeat (4) @(posedge core_clk);
    rd(UHFP_PORT_OFS, 32'h0000_3101);
    chk({28'h0, port_power_out, port_owner_out, port_reset_drive, schedule_run}, 32'hE);
    repeat (UHFP_BUSRST_CYC) @(posedge core_clk);
    rd(UHFP_PORT_OFS, 32'h0000_3805);
    wr(UHFP_PORT_OFS, 32'h0000_1084);
    rd(UHFP_PORT_OFS, 32'h0000_3885);
    wr(UHFP_PORT_OFS, 32'h0000_10C4);
    repeat (4) @(posedge core_clk);
    rd(UHFP_PORT_OFS, 32'h0000_34C5);
    chk({30'h0, port_suspend_out, resume_drive}, 32'h3);
  endtask
  task automatic t_frame();
    wr(UHFP_FRIDX_OFS, 32'hFFFF_FFFF);
    rd(UHFP_FRIDX_OFS, 32'h0000_3FFF);
    chk({18'h0, sof_frame_number}, 32'h3FFF);
    bus(1'b0, UHFP_FRIDX_OFS, 32'h0, 4'h3);
    idle();
    rd(UHFP_FRIDX_OFS, 32'h0000_3FFF);
    chk({22'h0, frame_list_entry}, 32'h3FF);
    wr(UHFP_CMD_OFS, 32'h4);
    chk({22'h0, frame_list_entry}, 32'h1FF);
    wr(UHFP_CMD_OFS, 32'h8);
    chk({22'h0, frame_list_entry}, 32'h0FF);
    wr(UHFP_CMD_OFS, 32'h1);
    for (int i = 0; i < 6000 && sof_frame_number === 14'h3FFF; i++) @(posedge core_clk);
    chk({18'h0, sof_frame_number}, 32'h0);
    repeat (UHFP_UFRAME_CYC - 2) @(posedge core_clk);
    chk({18'h0, sof_frame_number}, 32'h0);
    repeat (2) @(posedge core_clk);
    chk({18'h0, sof_frame_number}, 32'h1);
    wr(UHFP_CMD_OFS, 32'h0);
    repeat (UHFP_UFRAME_CYC + 10) @(posedge core_clk);
    rd(UHFP_FRIDX_OFS, 32'h1);
  endtask
  task automatic t_controller_reset_cmd();
    wr(UHFP_CMD_OFS, 32'h2);
    repeat (3) @(posedge core_clk);
    rd(UHFP_PORT_OFS, 32'h0000_2000);
    rd(UHFP_FRIDX_OFS, 32'h0);
  endtask
  // Hang guard, well above the longest expected run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      $display("CHECK FAILED %0t timeout", $time);
      complete_run();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_power();
    t_owner();
    t_busreset();
    t_frame();
    t_controller_reset_cmd();
    complete_run();
  end
endmodule
